// ==== shared/seq_pkg.sv ====
// Purpose: Shared constants and types for the start-up configuration sequencer
// Assumes: 50 MHz system clock
// Notes: Regulator bit vector order is fixed by the reg_* indices below
package seq_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned STRAP_SAMPLE_DELAY_NS = 1000;
    localparam int unsigned STRAP_SAMPLE_CYCLES = (STRAP_SAMPLE_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned WAKE_FILTER_TIME_NS = 2000;
    localparam int unsigned WAKE_FILTER_CYCLES = (WAKE_FILTER_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned MASTER_WAIT_TIME_US = 1000;
    localparam int unsigned MASTER_WAIT_CYCLES = MASTER_WAIT_TIME_US * (CLK_HZ / 1_000_000);
    localparam int unsigned OSC_NOMINAL_HZ = 16_000_000;
    localparam int unsigned OSC_DIV = CLK_HZ / OSC_NOMINAL_HZ;

    // Regulator indices in the enable / good vectors
    localparam int unsigned NUM_REGS = 5;
    localparam int unsigned REG_MAIN_SW = 0;
    localparam int unsigned REG_MAIN_LIN = 1;
    localparam int unsigned REG_AUX1 = 2;
    localparam int unsigned REG_AUX2 = 3;
    localparam int unsigned REG_CTRL = 4;
    localparam int unsigned MAX_STEPS = 4;

    typedef enum logic [1:0] {
        STRAP_LOW,
        STRAP_HIGH,
        STRAP_OPEN
    } strap_t;

    typedef enum logic [1:0] {
        MAJOR_BASIC,
        MAJOR_SINGLE,
        MAJOR_MASTER,
        MAJOR_SLAVE
    } major_t;

    typedef enum logic [2:0] {
        MINOR_BRIDGE,
        MINOR_PRIMARY_REGULATOR,
        MINOR_REGULATORS,
        MINOR_SIMPLE_REGULATOR,
        MINOR_BRIDGE_EXT_FET,
        MINOR_SECONDARY_REGULATORS,
        MINOR_NONE
    } minor_t;
endpackage : seq_pkg

// ==== design/strap_decoder.sv ====
// Purpose: Decode one three-state strap pin from its pulled-high and pulled-low readings
// Assumes: Readings are already synchronised
// Notes: Open pin follows the test pull, tied pin does not
`timescale 1ns/100ps
module strap_decoder
    import seq_pkg::*;
(
    // Readings
    input wire logic seen_with_pullup_i,
    input wire logic seen_with_pulldown_i,
    // Decoded state
    output strap_t state_o
);
    always_comb begin
        if (seen_with_pullup_i && seen_with_pulldown_i) begin
            state_o = STRAP_HIGH;
        end else if (!seen_with_pullup_i && !seen_with_pulldown_i) begin
            state_o = STRAP_LOW;
        end else begin
            state_o = STRAP_OPEN;
        end
    end
endmodule : strap_decoder

// ==== design/startup_config_power_sequencer.sv ====
// Purpose: Strap decode and power-up sequencing with companion wake handshake
// Assumes: Regulator good and supply good inputs arrive asynchronously
// Notes: Regulator analog parts, undervoltage filters and hibernate live elsewhere
`timescale 1ns/100ps
// Contract
// [RULE_01] Time base ticks from free-running oscillator, stopped only in low power.
// [RULE_02] Each strap pin decodes as ground 0, supply 1 or open Z.
// [RULE_03] After logic supply good, enable first strap sense, sample after delay.
// [RULE_04] First strap open selects basic mode, other straps ignored.
// [RULE_05] Major mode from straps: 00x single, 01/10 master, 1Zx/11x slave.
// [RULE_06] Minor mode from six combinations, third pin fastest as 0,Z,1.
// [RULE_07] Basic: aux one, aux two, main linear, then main switcher non-system.
// [RULE_08] Slave: wake pin is digital enable, pull-up disabled.
// [RULE_09] Slave: filtered low enters low power, filtered high starts up.
// [RULE_10] Master: start without enable, hold slave-enable low during start-up.
// [RULE_11] Master: slave-enable high after start-up until system regulator undervoltage.
// [RULE_12] Master low-power command: slave-enable low now, wait, then enter.
// [RULE_13] Single acts as master without slave-enable and without wait.
// [RULE_14] Listed regulators are system regulators, enabled in listed order.
// [RULE_15] Bridge minor: main switcher then main linear.
// [RULE_16] Primary: aux one, main switcher with linear, aux two non-system.
// [RULE_17] Regulators minor: main switcher, aux one, aux two.
// [RULE_18] Simple: aux one, aux two, main linear, main switcher non-system.
// [RULE_19] Ext-FET minor: main switcher, controller regulator, main linear.
// [RULE_20] Secondary minor: main switcher, paralleled aux three, main linear.
// [RULE_21] Normal operation only when supplies, pump and system regulators good; in run the code drops reset on pump or system regulator loss only.
// [RULE_22] Order: logic supply, straps, slave wait, pump, regulators, enable, I/O.
// [RULE_23] Each step waits for previous regulator good; grouped ones share a step.
module startup_config_power_sequencer
    import seq_pkg::*;
#(
    parameter int unsigned MASTER_WAIT = MASTER_WAIT_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Supplies and regulator status (asynchronous)
    input wire logic logic_supply_ok_i,
    input wire logic charge_pump_ok_i,
    input wire logic io_supply_ok_i,
    input wire logic [NUM_REGS-1:0] reg_good_i,
    // Strap pins (asynchronous)
    input wire logic [2:0] strap_pin_i,
    // Wake pin and low power command
    input wire logic wake_in_n_i,
    input wire logic low_power_cmd_i,
    // Outputs
    output logic strap_sense_en_o,
    output logic strap_pull_up_o,
    output logic osc_tick_o,
    output logic wake_pullup_en_o,
    output logic wake_pulldown_en_o,
    output logic slave_enable_o,
    output logic slave_enable_oe_n_o,
    output logic charge_pump_en_o,
    output logic [NUM_REGS-1:0] reg_enable_o,
    output logic [NUM_REGS-1:0] system_reg_o,
    output logic reset_out_n_o,
    output logic low_power_o,
    output major_t major_mode_o,
    output minor_t minor_mode_o
);
    if (MASTER_WAIT < 1) begin : g_bad_wait
        $error("MASTER_WAIT must be at least one cycle");
    end

    typedef enum logic [3:0] {ST_WAIT_LOGIC, ST_SENSE_UP, ST_SENSE_DOWN, ST_WAIT_WAKE, ST_PUMP, ST_REGS,
        ST_WAIT_IO, ST_RUN, ST_MASTER_WAIT, ST_LOW_POWER} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [2:0] logic_ok_sync, pump_ok_sync, io_ok_sync, wake_sync;
        logic [2:0] strap_up_seen;
        logic [NUM_REGS-1:0] good_s1, good_s2;
        logic [2:0] strap_s1, strap_s2;
        logic [31:0] timer;
        logic [15:0] wake_cnt;
        logic [2:0] step;
        logic [1:0] osc_cnt;
        logic wake_filtered, osc_tick, sense_en, pull_up, pu_en, pd_en;
        logic slave_en, slave_oe_n, pump_en, rst_out_n, low_power;
        logic [NUM_REGS-1:0] reg_en, sys_regs;
        major_t major;
        minor_t minor;
    } state_t;

    state_t st_reg;
    state_t st_next;
    strap_t pin_state [3];
    logic [NUM_REGS-1:0] plan_mask;
    logic [NUM_REGS-1:0] plan_sys;
    logic plan_last;
    logic sys_good;

    // ****************************************
    // Strap decoding
    // ****************************************
    // [RULE_02] three-state decode
    for (genvar g = 0; g < 3; g++) begin : g_strap
        strap_decoder u_dec (
            .seen_with_pullup_i(st_reg.strap_up_seen[g]),
            .seen_with_pulldown_i(st_reg.strap_s2[g]),
            .state_o(pin_state[g])
        );
    end

    function automatic logic [2:0] tri_index(input strap_t s);
        return (s == STRAP_OPEN) ? 3'h1 : ((s == STRAP_HIGH) ? 3'h2 : 3'h0);
    endfunction : tri_index

    // ****************************************
    // Power-up order per mode
    // ****************************************
    function automatic logic [NUM_REGS-1:0] bit_of(input int unsigned idx);
        return NUM_REGS'(1) << idx;
    endfunction : bit_of

    // [RULE_14] listed order, system regulators
    always_comb begin
        plan_mask = '0;
        plan_sys = '1;
        plan_last = 1'b0;
        case (st_reg.minor)
            MINOR_NONE, MINOR_SIMPLE_REGULATOR: begin
                // [RULE_07] basic order
                // [RULE_18] simple order, same
                case (st_reg.step)
                    3'h0: plan_mask = bit_of(REG_AUX1);
                    3'h1: plan_mask = bit_of(REG_AUX2);
                    3'h2: plan_mask = bit_of(REG_MAIN_LIN);
                    default: plan_mask = bit_of(REG_MAIN_SW);
                endcase
                plan_sys = ~bit_of(REG_MAIN_SW);
                plan_last = (st_reg.step == 3'h3);
            end
            MINOR_BRIDGE: begin
                // [RULE_15] bridge order
                plan_mask = (st_reg.step == 3'h0) ? bit_of(REG_MAIN_SW) : bit_of(REG_MAIN_LIN);
                plan_last = (st_reg.step == 3'h1);
            end
            MINOR_PRIMARY_REGULATOR: begin
                // [RULE_16] aux one, grouped main pair, aux two
                case (st_reg.step)
                    3'h0: plan_mask = bit_of(REG_AUX1);
                    3'h1: plan_mask = bit_of(REG_MAIN_SW) | bit_of(REG_MAIN_LIN);
                    default: plan_mask = bit_of(REG_AUX2);
                endcase
                plan_sys = ~bit_of(REG_AUX2);
                plan_last = (st_reg.step == 3'h2);
            end
            default: begin
                // [RULE_17] aux one, aux two
                // [RULE_19] controller regulator middle
                // [RULE_20] paralleled aux on aux one
                case (st_reg.step)
                    3'h0: plan_mask = bit_of(REG_MAIN_SW);
                    3'h1: plan_mask = bit_of(st_reg.minor == MINOR_BRIDGE_EXT_FET ? REG_CTRL : REG_AUX1);
                    default: plan_mask = bit_of(st_reg.minor == MINOR_REGULATORS ? REG_AUX2 : REG_MAIN_LIN);
                endcase
                plan_last = (st_reg.step == 3'h2);
            end
        endcase
    end

    // [RULE_21] system regulators all good
    assign sys_good = &(st_reg.good_s2 | ~(st_reg.reg_en & st_reg.sys_regs));

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.logic_ok_sync = {st_reg.logic_ok_sync[1:0], logic_supply_ok_i};
        st_next.pump_ok_sync = {st_reg.pump_ok_sync[1:0], charge_pump_ok_i};
        st_next.io_ok_sync = {st_reg.io_ok_sync[1:0], io_supply_ok_i};
        st_next.wake_sync = {st_reg.wake_sync[1:0], wake_in_n_i};
        st_next.good_s1 = reg_good_i;
        st_next.good_s2 = st_reg.good_s1;
        st_next.strap_s1 = strap_pin_i;
        st_next.strap_s2 = st_reg.strap_s1;

        // [RULE_01] tick generator halts in low power
        st_next.osc_tick = 1'b0;
        if (!st_reg.low_power) begin
            if (st_reg.osc_cnt == 2'(OSC_DIV - 1)) begin
                st_next.osc_cnt = 2'h0;
                st_next.osc_tick = 1'b1;
            end else begin
                st_next.osc_cnt = st_reg.osc_cnt + 2'h1;
            end
        end

        // Wake filter: level must hold for the full filter time
        if (st_reg.wake_sync[2] != st_reg.wake_sync[1]) begin
            st_next.wake_cnt = 16'h0;
        end else if (st_reg.wake_cnt == 16'(WAKE_FILTER_CYCLES)) begin
            st_next.wake_filtered = st_reg.wake_sync[2];
        end else begin
            st_next.wake_cnt = st_reg.wake_cnt + 16'h1;
        end

        case (st_reg.phase)
            ST_WAIT_LOGIC: begin
                // [RULE_03] logic supply then enable sense
                if (st_reg.logic_ok_sync[2]) begin
                    st_next.sense_en = 1'b1;
                    st_next.pull_up = 1'b1;
                    st_next.timer = '0;
                    st_next.phase = ST_SENSE_UP;
                end
            end
            ST_SENSE_UP: begin
                st_next.timer = st_reg.timer + 32'h1;
                // [RULE_03] sample after delay
                if (st_reg.timer == 32'(STRAP_SAMPLE_CYCLES)) begin
                    st_next.strap_up_seen = st_reg.strap_s2[2:0];
                    st_next.pull_up = 1'b0;
                    st_next.timer = '0;
                    st_next.phase = ST_SENSE_DOWN;
                end
            end
            ST_SENSE_DOWN: begin
                st_next.timer = st_reg.timer + 32'h1;
                if (st_reg.timer == 32'(STRAP_SAMPLE_CYCLES)) begin
                    st_next.sense_en = 1'b0;
                    st_next.timer = '0;
                    st_next.pd_en = 1'b0;
                    if (pin_state[0] == STRAP_OPEN) begin
                        // [RULE_04] basic ignores other straps
                        st_next.major = MAJOR_BASIC;
                        st_next.minor = MINOR_NONE;
                    end else begin
                        // [RULE_05] major mode table
                        if (pin_state[0] == STRAP_LOW && pin_state[1] != STRAP_HIGH) begin
                            st_next.major = MAJOR_SINGLE;
                        end else if (pin_state[0] == STRAP_LOW || pin_state[1] == STRAP_LOW) begin
                            st_next.major = MAJOR_MASTER;
                        end else begin
                            st_next.major = MAJOR_SLAVE;
                        end
                        // [RULE_06] rank over all three pins, mod six
                        st_next.minor = minor_t'(3'((5'(tri_index(pin_state[0])) * 5'h9 / 5'h2
                            + 5'(tri_index(pin_state[1])) * 5'h3 + 5'(tri_index(pin_state[2]))) % 5'h6));
                    end
                    if (pin_state[0] == STRAP_HIGH && pin_state[1] != STRAP_LOW) begin
                        // [RULE_08] digital input, no pull-up
                        st_next.pu_en = 1'b0;
                        st_next.pd_en = 1'b1;
                        st_next.phase = ST_WAIT_WAKE;
                    end else begin
                        st_next.pu_en = 1'b1;
                        st_next.pump_en = 1'b1;
                        st_next.phase = ST_PUMP;
                    end
                    // [RULE_10] master drives slave-enable low
                    if (pin_state[0] != STRAP_OPEN && pin_state[0] != pin_state[1]
                        && pin_state[1] != STRAP_OPEN) begin
                        st_next.slave_oe_n = 1'b0;
                    end
                end
            end
            ST_WAIT_WAKE: begin
                // [RULE_09] filtered wake level decides
                if (st_reg.wake_cnt == 16'(WAKE_FILTER_CYCLES)) begin
                    if (st_reg.wake_sync[2]) begin
                        st_next.pd_en = 1'b0;
                        st_next.pump_en = 1'b1;
                        st_next.phase = ST_PUMP;
                    end else begin
                        st_next.low_power = 1'b1;
                        st_next.phase = ST_LOW_POWER;
                    end
                end
            end
            ST_PUMP: begin
                // [RULE_22] pump before regulators
                if (st_reg.pump_ok_sync[2]) begin
                    st_next.step = 3'h0;
                    st_next.phase = ST_REGS;
                end
            end
            ST_REGS: begin
                // [RULE_23] step only after previous good
                if ((st_reg.reg_en & ~st_reg.good_s2) == '0) begin
                    st_next.reg_en = st_reg.reg_en | plan_mask;
                    st_next.sys_regs = st_reg.sys_regs | (plan_mask & plan_sys);
                    st_next.step = st_reg.step + 3'h1;
                    if (plan_last) begin
                        st_next.phase = ST_WAIT_IO;
                    end
                end
            end
            ST_WAIT_IO: begin
                // [RULE_21] release reset when everything good
                if ((st_reg.reg_en & ~st_reg.good_s2) == '0 && st_reg.pump_ok_sync[2]) begin
                    // [RULE_11] enable slaves after start-up
                    if (st_reg.major == MAJOR_MASTER) begin
                        st_next.slave_en = 1'b1;
                    end
                    if (st_reg.io_ok_sync[2]) begin
                        st_next.rst_out_n = 1'b1;
                        st_next.phase = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                // [RULE_11] drop slave-enable on undervoltage
                if (!sys_good || !st_reg.pump_ok_sync[2]) begin
                    st_next.slave_en = 1'b0;
                    st_next.rst_out_n = 1'b0;
                end else if (st_reg.io_ok_sync[2]) begin
                    st_next.rst_out_n = 1'b1;
                end
                if (st_reg.major == MAJOR_SLAVE) begin
                    if (st_reg.wake_filtered == 1'b0 && st_reg.wake_cnt == 16'(WAKE_FILTER_CYCLES)) begin
                        st_next.low_power = 1'b1;
                        st_next.phase = ST_LOW_POWER;
                    end
                end else if (low_power_cmd_i) begin
                    // [RULE_12] slave-enable low immediately
                    st_next.slave_en = 1'b0;
                    st_next.timer = '0;
                    if (st_reg.major == MAJOR_MASTER) begin
                        st_next.phase = ST_MASTER_WAIT;
                    end else begin
                        // [RULE_13] no wait outside master
                        st_next.low_power = 1'b1;
                        st_next.phase = ST_LOW_POWER;
                    end
                end
            end
            ST_MASTER_WAIT: begin
                st_next.timer = st_reg.timer + 32'h1;
                // [RULE_12] wait before own entry
                if (st_reg.timer == 32'(MASTER_WAIT - 1)) begin
                    st_next.low_power = 1'b1;
                    st_next.phase = ST_LOW_POWER;
                end
            end
            default: begin
                st_next.reg_en = '0;
                st_next.sys_regs = '0;
                st_next.pump_en = 1'b0;
                st_next.rst_out_n = 1'b0;
                st_next.slave_en = 1'b0;
                // Slave wakes on a filtered high wake level; others wake on a filtered low level
                if (st_reg.wake_cnt == 16'(WAKE_FILTER_CYCLES)
                    && st_reg.wake_sync[2] == (st_reg.major == MAJOR_SLAVE)) begin
                    st_next.low_power = 1'b0;
                    st_next.pump_en = 1'b1;
                    st_next.phase = ST_PUMP;
                end
            end
        endcase
        // [RULE_01] no tick once halted
        if (st_next.low_power) begin
            st_next.osc_tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            st_reg <= '0;
            st_reg.phase <= ST_WAIT_LOGIC;
            st_reg.pd_en <= 1'b1;
            st_reg.slave_oe_n <= 1'b1;
            st_reg.major <= MAJOR_BASIC;
            st_reg.minor <= MINOR_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign strap_sense_en_o = st_reg.sense_en;
    assign strap_pull_up_o = st_reg.pull_up;
    assign osc_tick_o = st_reg.osc_tick;
    assign wake_pullup_en_o = st_reg.pu_en;
    assign wake_pulldown_en_o = st_reg.pd_en;
    assign slave_enable_o = st_reg.slave_en;
    assign slave_enable_oe_n_o = st_reg.slave_oe_n;
    assign charge_pump_en_o = st_reg.pump_en;
    assign reg_enable_o = st_reg.reg_en;
    assign system_reg_o = st_reg.sys_regs;
    assign reset_out_n_o = st_reg.rst_out_n;
    assign low_power_o = st_reg.low_power;
    assign major_mode_o = st_reg.major;
    assign minor_mode_o = st_reg.minor;
endmodule : startup_config_power_sequencer

// ==== verif/seq_chk.sv ====
// Purpose: Port checks for the start-up sequencer
// Assumes: Supply ok inputs stay high after reset release
// Notes: Bound after endmodule
`timescale 1ns/100ps
module seq_chk
    import seq_pkg::*;
(
    // Inputs
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic charge_pump_ok_i,
    input wire logic io_supply_ok_i,
    input wire logic low_power_cmd_i,
    // Outputs
    input wire logic strap_sense_en_o,
    input wire logic osc_tick_o,
    input wire logic wake_pullup_en_o,
    input wire logic slave_enable_o,
    input wire logic slave_enable_oe_n_o,
    input wire logic charge_pump_en_o,
    input wire logic [NUM_REGS-1:0] reg_enable_o,
    input wire logic [NUM_REGS-1:0] system_reg_o,
    input wire logic reset_out_n_o,
    input wire logic low_power_o,
    input wire major_t major_mode_o,
    input wire minor_t minor_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    a_tick_stops: assert property (low_power_o |-> !osc_tick_o)
        else $error("tick in low power");
    a_tick_gap: assert property (osc_tick_o |=> !osc_tick_o [*2])
        else $error("ticks too close");
    a_sense_first: assert property (strap_sense_en_o |-> minor_mode_o == MINOR_NONE)
        else $error("mode set while sensing");
    a_sw_not_sys: assert property (major_mode_o == MAJOR_BASIC |-> !system_reg_o[REG_MAIN_SW])
        else $error("main switcher marked system");
    a_slave_pull: assert property (major_mode_o == MAJOR_SLAVE |-> !wake_pullup_en_o)
        else $error("pull-up on in slave");
    a_en_after: assert property ($rose(slave_enable_o) |-> major_mode_o == MAJOR_MASTER && reg_enable_o != '0)
        else $error("slave enable too early");
    a_oe_master: assert property (major_mode_o == MAJOR_MASTER |-> ##[0:2] !slave_enable_oe_n_o)
        else $error("enable pin not driven");
    a_lp_drop: assert property (low_power_cmd_i && slave_enable_o |=> !slave_enable_o)
        else $error("slave enable kept");
    a_run_ok: assert property (reset_out_n_o |-> charge_pump_ok_i && io_supply_ok_i)
        else $error("released without supplies");
    a_pump_first: assert property (reg_enable_o != '0 |-> charge_pump_en_o)
        else $error("regulator before pump");
    c_slave_en: cover property ($rose(slave_enable_o));
    c_lp: cover property ($rose(low_power_o));
    c_run: cover property ($rose(reset_out_n_o));
endmodule : seq_chk
bind startup_config_power_sequencer seq_chk chk_i (.clk_i, .reset_n_i, .charge_pump_ok_i, .io_supply_ok_i,
    .low_power_cmd_i, .strap_sense_en_o, .osc_tick_o, .wake_pullup_en_o, .slave_enable_o, .slave_enable_oe_n_o,
    .charge_pump_en_o, .reg_enable_o, .system_reg_o, .reset_out_n_o, .low_power_o, .major_mode_o, .minor_mode_o);

// ==== verif/pwr_model.sv ====
// Purpose: Straps, charge pump and regulator goods around the sequencer
// Assumes: Strap code per pin: bit1 open, bit0 tied level
// Notes: Slow mode delays goods by one more cycle
`timescale 1ns/100ps
module pwr_model
    import seq_pkg::*;
(
    // From block
    input wire logic clk_i,
    input wire logic [5:0] cfg_i,
    input wire logic slow_i,
    input wire logic pull_up_i,
    input wire logic pump_en_i,
    input wire logic [NUM_REGS-1:0] reg_en_i,
    // To block
    output logic [2:0] strap_o,
    output logic pump_ok_o,
    output logic [NUM_REGS-1:0] good_o
);
    logic pk = 1'b0;
    logic [NUM_REGS-1:0] d1 = '0;
    logic [NUM_REGS-1:0] d2 = '0;
    // An open pin follows the test pull, so one reading alone cannot see it
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            strap_o[i] = cfg_i[2*i+1] ? pull_up_i : cfg_i[2*i];
        end
    end
    always_ff @(posedge clk_i) begin
        pk <= pump_en_i;
        d1 <= reg_en_i;
        d2 <= d1;
    end
    assign pump_ok_o = pk;
    assign good_o = slow_i ? d2 : d1;
endmodule : pwr_model

// ==== verif/tb.sv ====
// Purpose: Self-checking bench for the start-up sequencer
// Assumes: Power model answers pump and regulator goods
// Notes: Master wait shortened to 10 cycles
`timescale 1ns/100ps
module tb;
    import seq_pkg::*;
    localparam int unsigned MW = 10;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic logic_supply_ok_i = 1'b0;
    logic io_supply_ok_i = 1'b0;
    logic wake_in_n_i = 1'b1;
    logic low_power_cmd_i = 1'b0;
    logic slow = 1'b0;
    logic [5:0] cfg = '0;
    logic [2:0] strap_pin_i;
    logic charge_pump_ok_i, strap_pull_up_o, charge_pump_en_o, slave_enable_o, reset_out_n_o, low_power_o;
    logic [NUM_REGS-1:0] reg_good_i, reg_enable_o, system_reg_o;
    major_t major_mode_o;
    minor_t minor_mode_o;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    always #10 clk_i = ~clk_i;
    startup_config_power_sequencer #(.MASTER_WAIT(MW)) DUT (.clk_i, .reset_n_i, .logic_supply_ok_i,
        .charge_pump_ok_i, .io_supply_ok_i, .reg_good_i, .strap_pin_i, .wake_in_n_i, .low_power_cmd_i,
        .strap_sense_en_o(), .strap_pull_up_o, .osc_tick_o(), .wake_pullup_en_o(), .wake_pulldown_en_o(),
        .slave_enable_o, .slave_enable_oe_n_o(), .charge_pump_en_o, .reg_enable_o, .system_reg_o,
        .reset_out_n_o, .low_power_o, .major_mode_o, .minor_mode_o);
    pwr_model PM (.clk_i, .cfg_i(cfg), .slow_i(slow), .pull_up_i(strap_pull_up_o), .pump_en_i(charge_pump_en_o),
        .reg_en_i(reg_enable_o), .strap_o(strap_pin_i), .pump_ok_o(charge_pump_ok_i), .good_o(reg_good_i));
    task automatic tally_and_finish();
        if (mismatches == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            mismatches++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    // Reset, boot with given straps and log each new set of regulator enables
    task automatic boot(input logic [5:0] c, input logic [19:0] order);
        logic [19:0] hist;
        hist = '0;
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        logic_supply_ok_i <= 1'b0;
        cfg <= c;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        logic_supply_ok_i <= 1'b1;
        io_supply_ok_i <= 1'b1;
        for (int i = 0; i < 2000 && reset_out_n_o !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
            if (reg_enable_o != hist[4:0]) hist = {hist[14:0], reg_enable_o};
        end
        chk(hist, order);
    endtask : boot
    task automatic lp_cmd(input int unsigned wait_n);
        @(posedge clk_i);
        low_power_cmd_i <= 1'b1;
        @(posedge clk_i);
        low_power_cmd_i <= 1'b0;
        repeat (wait_n) @(posedge clk_i);
        #1;
    endtask : lp_cmd
    task automatic run_basic();
        boot(6'b000010, 20'h231CF);
        chk(20'(major_mode_o), 20'(MAJOR_BASIC));
        chk(20'(system_reg_o), 20'h0000E);
        chk(20'(reset_out_n_o), 20'h1);
    endtask : run_basic
    task automatic run_master();
        boot(6'b000100, 20'h00023);
        chk(20'(major_mode_o), 20'(MAJOR_MASTER));
        chk(20'(minor_mode_o), 20'(MINOR_BRIDGE));
        chk(20'(system_reg_o), 20'h00003);
        chk(20'(slave_enable_o), 20'h1);
        lp_cmd(MW - 4);
        chk(20'({slave_enable_o, low_power_o}), 20'h0);
        repeat (5) @(posedge clk_i);
        chk(20'(low_power_o), 20'h1);
    endtask : run_master
    task automatic run_single();
        slow <= 1'b1;
        boot(6'b100000, 20'h010EF);
        chk(20'(major_mode_o), 20'(MAJOR_SINGLE));
        chk(20'(minor_mode_o), 20'(MINOR_PRIMARY_REGULATOR));
        chk(20'({system_reg_o, slave_enable_o}), 20'h0E);
        lp_cmd(2);
        chk(20'(low_power_o), 20'h1);
    endtask : run_single
    task automatic run_slave();
        @(posedge clk_i) wake_in_n_i <= 1'b0;
        boot(6'b001001, 20'h0);
        chk(20'({low_power_o, reset_out_n_o}), 20'h2);
        chk(20'(major_mode_o), 20'(MAJOR_SLAVE));
        chk(20'(minor_mode_o), 20'(MINOR_BRIDGE));
    endtask : run_slave
    initial begin
        run_basic();
        run_master();
        run_single();
        run_slave();
        tally_and_finish();
    end
endmodule : tb
